// *** smu_mem_model.sv ***
// Behavioural X and Y data memories facing the move unit.
// Assumes the unit's request struct and the one core clock.
`timescale 1ns/10ps
`default_nettype none

module smu_mem_model
  import smu_pkg::*;
(
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // Memory port
  input  wire smu_mem_req_s req_i,
  output logic [DATA_W-1:0] x_o,
  output logic [DATA_W-1:0] y_o
);
  logic [DATA_W-1:0] xm [0:63];
  logic [DATA_W-1:0] ym [0:63];

  initial begin
    for (int i = 0; i < 64; i++) begin
      xm[i] = 32'hC35A_0000 + i;
      ym[i] = 32'h1E0F_0000 + i;
    end
  end

  // Read data stands while the strobe stands, so the unit samples it at the next edge.
  // Outside the read cycle the bus shows the inverse, so stale data never looks valid.
  always_comb begin
    x_o = req_i.x_rd ? xm[req_i.addr[5:0]] : ~xm[req_i.addr[5:0]];
    y_o = req_i.y_rd ? ym[req_i.addr[5:0]] : ~ym[req_i.addr[5:0]];
  end

  always @(posedge clk_i) begin
    if (rst_n_i) begin
      if (req_i.x_wr) begin
        xm[req_i.addr[5:0]] <= req_i.wdata;
      end
      if (req_i.y_wr) begin
        ym[req_i.addr[5:0]] <= req_i.wdata;
      end
    end
  end
endmodule // smu_mem_model

`default_nettype wire

// *** smu_move_unit.sv ***
// Single multifunction move unit: decodes the move slot and keeps the datapath registers.
// Assumes memory read data returns one cycle after the request; sequencing issues one word a cycle.
`timescale 1ns/10ps
`default_nettype none

module smu_move_unit
  import smu_pkg::*;
#(
  parameter int NUM_IDX = 8
) (
  // Clock and reset
  input  wire logic              MCLK_I,
  input  wire logic              ARST_N_I,
  // Instruction
  input  wire logic              INSTR_VALID_I,
  input  wire logic [31:0]       INSTR_I,
  input  wire smu_acc_wr_s       ARITH_WR_I,
  // Data memories
  input  wire logic [DATA_W-1:0] X_RDATA_I,
  input  wire logic [DATA_W-1:0] Y_RDATA_I,
  output var  smu_mem_req_s      MEM_REQ_O,
  // Flags
  input  wire logic              FLAG_CLR_I,
  output logic                   LIMIT_O,
  output logic [1:0]             SHIFT_O,
  output logic                   PAIR_REJECT_O,
  // Observation
  input  wire logic [3:0]        PEEK_SEL_I,
  output logic [DATA_W-1:0]      PEEK_DATA_O
);

  // ---------------------------------------------------------------------------
  // Register files
  // ---------------------------------------------------------------------------
  logic [DATA_W-1:0] opx [4];
  logic [DATA_W-1:0] opy [4];
  logic [ACC_W-1:0]  acc [8];
  logic [ADDR_W-1:0] idx [NUM_IDX];
  logic [ADDR_W-1:0] modr [NUM_IDX];

  // Saturate an accumulator to 32 bits; returns value, limit and shift code.
  // The low half is dropped without rounding; only guard and high-part sign are judged.
  function automatic logic [DATA_W+2:0] sat_read(input logic [ACC_W-1:0] a);
    logic [DATA_W-1:0] hi;
    logic              ovf;
    hi  = a[ACC_W-GUARD_W-1 -: DATA_W];
    ovf = (a[ACC_W-1:ACC_W-GUARD_W-1] != {(GUARD_W+1){a[ACC_W-1]}});
    if (ovf) begin
      hi = a[ACC_W-1] ? 32'h8000_0000 : 32'h7FFF_FFFF;
    end
    sat_read = {hi, ovf, ovf ? SHIFT_ONE : SHIFT_NONE};
  endfunction

  // Read one of the sixteen datapath registers as a 32-bit value.
  function automatic logic [DATA_W-1:0] dp_value(input logic [3:0] s,
                                                  input logic [DATA_W-1:0] sat);
    case (s[3:2])
      2'h0:    dp_value = opx[s[1:0]];
      2'h1:    dp_value = opy[s[1:0]];
      default: dp_value = sat;
    endcase
  endfunction

  // ---------------------------------------------------------------------------
  // Decode of the move slot
  // ---------------------------------------------------------------------------
  logic [15:0]       slot;
  smu_op_e           op;
  logic              use_y;
  logic              direct;
  logic [3:0]        dp_sel;
  logic [2:0]        idx_sel;
  smu_upd_e          upd;
  logic [5:0]        any_sel;
  logic [ADDR_W-1:0] base;
  logic [ADDR_W-1:0] next_idx;
  logic [DATA_W+2:0] sat;
  logic              src_acc;
  logic              go;
  logic [DATA_W-1:0] dp_src;

  // The move slot sits above the arithmetic slot; both execute this cycle. RULE_16
  assign slot    = INSTR_I[SLOT_LSB +: 16]; // RULE_15
  assign op      = smu_op_e'(slot[OP_LSB +: 4]);
  assign use_y   = slot[MEM_BIT];
  assign direct  = slot[DIRECT_BIT];
  assign dp_sel  = slot[DP_LSB +: 4];
  assign upd     = smu_upd_e'(slot[UPD_LSB +: 2]);
  assign idx_sel = slot[IDX_LSB +: 3];
  assign any_sel = slot[ANY_LSB +: 6];
  assign go      = INSTR_VALID_I;
  assign src_acc = dp_sel[3];
  assign sat     = sat_read(acc[dp_sel[2:0]]);
  // Accumulator sources of stores and from-datapath moves pass only through saturation.
  assign dp_src  = dp_value(dp_sel, sat[DATA_W+2:3]);

  // Memory address: direct 6-bit field or the index value before update. RULE_01 RULE_17
  assign base = direct ? {{(ADDR_W-DIR_W){1'b0}}, slot[DIR_W-1:0]} : idx[idx_sel];

  always_comb begin
    case (upd)
      UPD_INC: next_idx = base + 16'h0001; // RULE_02
      UPD_DEC: next_idx = base - 16'h0001;
      UPD_MOD: next_idx = base + modr[idx_sel];
      default: next_idx = base;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Memory request
  // ---------------------------------------------------------------------------
  // Strobes are one-cycle pulses; a word that is not a memory move leaves them low.
  smu_mem_req_s next_req;

  always_comb begin
    next_req       = '0;
    next_req.x_rd  = go && op == OP_LOAD && !use_y; // RULE_01
    next_req.y_rd  = go && op == OP_LOAD && use_y;
    next_req.x_wr  = go && op == OP_STORE && !use_y;
    next_req.y_wr  = go && op == OP_STORE && use_y;
    next_req.addr  = base;
    next_req.wdata = dp_src; // RULE_06
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      MEM_REQ_O <= '0;
    end else begin
      MEM_REQ_O <= next_req;
    end
  end

  // ---------------------------------------------------------------------------
  // Index pointers and modifiers
  // ---------------------------------------------------------------------------
  // Index update written after the access has used the old value. RULE_17
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      for (int i = 0; i < NUM_IDX; i++) begin
        idx[i]  <= INDEX_RST;
        modr[i] <= MOD_RST;
      end
    end else if (go) begin
      if ((op == OP_LOAD || op == OP_STORE) && !direct && upd != UPD_NONE) begin
        idx[idx_sel] <= next_idx; // RULE_02
      end else if (op == OP_FROM_DP && any_sel[5:4] == 2'h3) begin
        if (any_sel[3]) begin
          modr[any_sel[2:0]] <= dp_src[ADDR_W-1:0];
        end else begin
          idx[any_sel[2:0]] <= dp_src[ADDR_W-1:0];
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Load return: data arrives one cycle after the read request
  // ---------------------------------------------------------------------------
  // Only the destination and the X or Y choice are remembered; the returning data is never buffered.
  logic       ld_pend;
  logic       ld_y;
  logic [3:0] ld_dst;

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ld_pend <= 1'b0;
      ld_y    <= 1'b0;
      ld_dst  <= 4'h0;
    end else begin
      ld_pend <= go && op == OP_LOAD;
      ld_y    <= use_y;
      ld_dst  <= dp_sel; // RULE_05
    end
  end

  // ---------------------------------------------------------------------------
  // Any-register source
  // ---------------------------------------------------------------------------
  // Source for moves into a datapath register from any register.
  logic [DATA_W-1:0] any_value;
  logic [ACC_W-1:0]  any_acc;

  assign any_acc = acc[any_sel[2:0]];

  always_comb begin
    case (any_sel[5:3])
      3'h0:    any_value = opx[any_sel[1:0]];
      3'h1:    any_value = opy[any_sel[1:0]];
      3'h2:    any_value = any_acc[ACC_W-GUARD_W-1 -: DATA_W];
      3'h3:    any_value = any_acc[DATA_W-1:0];
      3'h4:    any_value = {{(DATA_W-GUARD_W){any_acc[ACC_W-1]}}, any_acc[ACC_W-1 -: GUARD_W]};
      3'h6:    any_value = {{(DATA_W-ADDR_W){1'b0}}, idx[any_sel[2:0]]};
      3'h7:    any_value = {{(DATA_W-ADDR_W){1'b0}}, modr[any_sel[2:0]]};
      default: any_value = any_acc[ACC_W-GUARD_W-1 -: DATA_W];
    endcase
  end

  // Sign extension into the guard, value into the high part, low cleared.
  function automatic logic [ACC_W-1:0] acc_load(input logic [DATA_W-1:0] v);
    acc_load = {{GUARD_W{v[DATA_W-1]}}, v, {DATA_W{1'b0}}}; // RULE_13 RULE_10 RULE_12
  endfunction

  // ---------------------------------------------------------------------------
  // Operand registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      for (int i = 0; i < 4; i++) begin
        opx[i] <= DATA_RST;
        opy[i] <= DATA_RST;
      end
    end else begin
      if (ld_pend && !ld_dst[3]) begin
        if (ld_dst[2]) begin
          opy[ld_dst[1:0]] <= ld_y ? Y_RDATA_I : X_RDATA_I; // RULE_05
        end else begin
          opx[ld_dst[1:0]] <= ld_y ? Y_RDATA_I : X_RDATA_I;
        end
      end
      if (go && op == OP_TO_DP && !dp_sel[3]) begin
        if (dp_sel[2]) begin
          opy[dp_sel[1:0]] <= any_value; // RULE_09
        end else begin
          opx[dp_sel[1:0]] <= any_value;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Accumulators
  // ---------------------------------------------------------------------------
  // The arithmetic slot writes first; a move into the same accumulator wins.
  // A load landing late loses to a move issued this cycle, which is later in program order.
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      for (int i = 0; i < 8; i++) begin
        acc[i] <= ACC_RST;
      end
    end else begin
      if (ARITH_WR_I.valid) begin
        acc[ARITH_WR_I.sel] <= ARITH_WR_I.value; // RULE_03
      end
      if (ld_pend && ld_dst[3]) begin
        acc[ld_dst[2:0]] <= acc_load(ld_y ? Y_RDATA_I : X_RDATA_I);
      end
      if (go && op == OP_TO_DP && dp_sel[3]) begin
        acc[dp_sel[2:0]] <= acc_load(any_value); // RULE_11
      end
      if (go && op == OP_FROM_DP && any_sel[5:4] == 2'h2) begin
        // Same contents a multiply-by-one load would leave. RULE_14
        acc[any_sel[2:0]] <= acc_load(dp_src);
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Sticky flags
  // ---------------------------------------------------------------------------
  logic       flag_evt;
  logic       limit_set;
  logic       shift_set;
  logic       next_limit;
  logic [1:0] next_shift;

  assign flag_evt  = go && src_acc && (op == OP_STORE || op == OP_FROM_DP); // RULE_06
  assign limit_set = flag_evt && sat[2];
  assign shift_set = flag_evt && sat[1:0] != SHIFT_NONE;

  // A set in the same cycle as a software clear wins, so no saturation goes unseen. RULE_07
  always_comb begin
    next_limit = LIMIT_O;
    if (limit_set) begin
      next_limit = 1'b1;
    end else if (FLAG_CLR_I) begin
      next_limit = 1'b0; // RULE_07
    end
  end

  // A higher shift code is kept; 11b can never form. RULE_08
  always_comb begin
    next_shift = SHIFT_O;
    if (shift_set) begin
      next_shift = (FLAG_CLR_I || sat[1:0] > SHIFT_O) ? sat[1:0] : SHIFT_O;
    end else if (FLAG_CLR_I) begin
      next_shift = SHIFT_NONE;
    end
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      LIMIT_O <= 1'b0;
    end else begin
      LIMIT_O <= next_limit;
    end
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      SHIFT_O <= SHIFT_RST;
    end else begin
      SHIFT_O <= next_shift;
    end
  end

  // ---------------------------------------------------------------------------
  // Refused words
  // ---------------------------------------------------------------------------
  // Two-move words belong to the parallel move unit. RULE_04
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      PAIR_REJECT_O <= 1'b0;
    end else begin
      PAIR_REJECT_O <= go && op == OP_PAIR;
    end
  end

  // ---------------------------------------------------------------------------
  // Observation
  // ---------------------------------------------------------------------------
  // Accumulators show their high part raw, without saturation, so a test sees exactly what landed there.
  logic [DATA_W-1:0] next_peek;
  logic [ACC_W-1:0]  peek_acc;

  assign peek_acc = acc[PEEK_SEL_I[2:0]];

  always_comb begin
    case (PEEK_SEL_I[3:2])
      2'h0:    next_peek = opx[PEEK_SEL_I[1:0]];
      2'h1:    next_peek = opy[PEEK_SEL_I[1:0]];
      default: next_peek = peek_acc[ACC_W-GUARD_W-1 -: DATA_W];
    endcase
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      PEEK_DATA_O <= DATA_RST;
    end else begin
      PEEK_DATA_O <= next_peek;
    end
  end

endmodule : smu_move_unit

`default_nettype wire

// *** smu_move_unit_asserts.sv ***
// Port checker for the single move unit.
// Assumes it is bound to smu_move_unit and sees only its ports.
`timescale 1ns/10ps
`default_nettype none

module smu_move_chk
  import smu_pkg::*;
#(
  parameter int NUM_IDX = 8
) (
  // Clock and reset
  input wire logic         MCLK_I,
  input wire logic         ARST_N_I,
  // Watched ports
  input wire logic         INSTR_VALID_I,
  input wire logic [31:0]  INSTR_I,
  input wire smu_mem_req_s MEM_REQ_O,
  input wire logic         FLAG_CLR_I,
  input wire logic         LIMIT_O,
  input wire logic [1:0]   SHIFT_O,
  input wire logic         PAIR_REJECT_O
);
  wire logic        v    = INSTR_VALID_I;
  wire logic [15:0] s    = INSTR_I[31:16];
  wire logic [3:0]  op   = s[15:12];
  wire logic        msel = s[11];
  wire logic [5:0]  dadr = s[5:0];
  wire logic [15:0] adr  = MEM_REQ_O.addr;
  wire logic [3:0]  stb  = {MEM_REQ_O.x_rd, MEM_REQ_O.x_wr, MEM_REQ_O.y_rd, MEM_REQ_O.y_wr};

  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!ARST_N_I);

  chk_load_strobe:
    assert property (v && op == 4'h1 |=> stb == ($past(msel) ? 4'h2 : 4'h8))
      else $error("Load strobe wrong.");
  chk_store_strobe:
    assert property (v && op == 4'h2 |=> stb == ($past(msel) ? 4'h1 : 4'h4))
      else $error("Store strobe wrong.");
  chk_direct_addr:
    assert property (v && (op == 4'h1 || op == 4'h2) && s[10] |=> adr == {10'h000, $past(dadr)})
      else $error("Direct address wrong.");
  chk_index_step:
    assert property (v && op == 4'h1 && !s[10] && s[5:4] == 2'h1
      ##1 v && {s[15:10], s[5:0]} == $past({s[15:10], s[5:0]})
      |=> adr == $past(adr) + 16'h0001) else $error("Index step wrong.");
  chk_pair_refused:
    assert property (v && op == 4'h5 |=> PAIR_REJECT_O && stb == 4'h0)
      else $error("Pair word not refused.");
  chk_idle_quiet:
    assert property (!v |=> stb == 4'h0) else $error("Strobe without word.");
  chk_shift_legal:
    assert property (SHIFT_O != 2'h3) else $error("Illegal shift code.");
  chk_limit_sticky:
    assert property ($fell(LIMIT_O) |-> $past(FLAG_CLR_I)) else $error("Limit self-cleared.");
  chk_load_flags:
    assert property (v && op == 4'h1 && !FLAG_CLR_I |=> $stable(LIMIT_O) && $stable(SHIFT_O))
      else $error("Load changed flags.");
endmodule // smu_move_chk

bind smu_move_unit smu_move_chk #(.NUM_IDX(NUM_IDX)) chk_u (
  .MCLK_I(MCLK_I), .ARST_N_I(ARST_N_I), .INSTR_VALID_I(INSTR_VALID_I),
  .INSTR_I(INSTR_I), .MEM_REQ_O(MEM_REQ_O), .FLAG_CLR_I(FLAG_CLR_I),
  .LIMIT_O(LIMIT_O), .SHIFT_O(SHIFT_O), .PAIR_REJECT_O(PAIR_REJECT_O));

`default_nettype wire

// *** smu_pkg.sv ***
// Constants, field layouts and carrier types of the single multifunction move unit.
// Assumes one core clock; memories and instruction sequencing sit outside the unit.
// Function
// RULE_01: Move between datapath register and either memory, by index pointer or 6-bit address.
// RULE_02: Indexed memory moves optionally update the index pointer per the update field.
// RULE_03: A single move runs together with the arithmetic instruction packed beside it.
// RULE_04: An instruction holding two data moves is a parallel move, not handled here.
// RULE_05: Memory loads target only the sixteen datapath registers and leave flags unchanged.
// RULE_06: Stores source only datapath registers; accumulator sources update limit and shift bits.
// RULE_07: Limit and shift bits are sticky; only an explicit software write clears them.
// RULE_08: The two shift bits only ever hold 10b, 01b or 00b.
// RULE_09: Moves into datapath registers accept guard, high, low, index and modifier sources.
// RULE_10: A plain accumulator load from a datapath register fills the high portion.
// RULE_11: Accumulator loads from datapath registers bypass the shift round saturate unit; a from-datapath move saturates an accumulator source.
// RULE_12: Accumulator loads apply no automatic one-bit left shift.
// RULE_13: Accumulator loads sign-extend into the guard bits.
// RULE_14: Plain move and multiply-by-one load leave identical accumulator contents.
// RULE_15: The plain accumulator load decodes as a 16-bit move in the move slot.
// RULE_16: One move and one arithmetic operation share a 32-bit word, same cycle.
// RULE_17: Indexed access uses the pre-update index; the updated index is written afterwards.
package smu_pkg;

  // ---------------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------------
  localparam int DATA_W  = 32;
  localparam int GUARD_W = 8;
  localparam int ACC_W   = GUARD_W + 2 * DATA_W;
  localparam int ADDR_W  = 16;
  localparam int DIR_W   = 6;

  // ---------------------------------------------------------------------------
  // Move slot fields (upper half of the instruction word)
  // ---------------------------------------------------------------------------
  localparam int SLOT_LSB   = 16;
  localparam int OP_LSB     = 12;
  localparam int MEM_BIT    = 11;
  localparam int DIRECT_BIT = 10;
  localparam int DP_LSB     = 6;
  localparam int UPD_LSB    = 4;
  localparam int IDX_LSB    = 0;
  localparam int ANY_LSB    = 0;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [DATA_W-1:0] DATA_RST  = 32'h0000_0000;
  localparam logic [ACC_W-1:0]  ACC_RST   = 72'h00_0000_0000_0000_0000;
  localparam logic [ADDR_W-1:0] INDEX_RST = 16'h0000;
  localparam logic [ADDR_W-1:0] MOD_RST   = 16'h0001;
  localparam logic [1:0]        SHIFT_RST = 2'h0;

  // Shift indication codes.
  localparam logic [1:0] SHIFT_NONE = 2'h0;
  localparam logic [1:0] SHIFT_ONE  = 2'h1;
  localparam logic [1:0] SHIFT_TWO  = 2'h2;

  typedef enum logic [3:0] {
    OP_NOP     = 4'h0,
    OP_LOAD    = 4'h1,
    OP_STORE   = 4'h2,
    OP_TO_DP   = 4'h3,
    OP_FROM_DP = 4'h4,
    OP_PAIR    = 4'h5
  } smu_op_e;

  typedef enum logic [1:0] {
    UPD_NONE = 2'h0,
    UPD_INC  = 2'h1,
    UPD_DEC  = 2'h2,
    UPD_MOD  = 2'h3
  } smu_upd_e;

  // Memory request toward either data memory.
  typedef struct packed {
    logic              x_rd;
    logic              x_wr;
    logic              y_rd;
    logic              y_wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } smu_mem_req_s;

  // Accumulator write from the arithmetic slot of the same word.
  typedef struct packed {
    logic              valid;
    logic [2:0]        sel;
    logic [ACC_W-1:0]  value;
  } smu_acc_wr_s;

endpackage : smu_pkg

// *** tb_top.sv ***
// Self-checking bench for the single move unit and its data memories.
// Assumes requests appear one edge after the word and peeks are registered.
`timescale 1ns/10ps
`default_nettype none

module tb_top
  import smu_pkg::*;
;
  logic              clk   = 1'b0;
  logic              rst_n = 1'b0;
  logic              vld   = 1'b0;
  logic [31:0]       ins   = 32'h0;
  smu_acc_wr_s       aw    = '0;
  logic              fclr  = 1'b0;
  logic [3:0]        psel  = 4'h0;
  logic [DATA_W-1:0] xd;
  logic [DATA_W-1:0] yd;
  logic [DATA_W-1:0] pk;
  smu_mem_req_s      rq;
  logic              lim;
  logic              rej;
  logic [1:0]        sh;
  int                errors = 0;
  int                checks = 0;
  wire logic [31:0]  stb = {28'h0, rq.x_rd, rq.x_wr, rq.y_rd, rq.y_wr};
  wire logic [31:0]  adr = {16'h0, rq.addr};
  wire logic [31:0]  flg = {29'h0, lim, sh};

  always #2 clk = ~clk;

  smu_move_unit #(.NUM_IDX(8)) dut_u (.MCLK_I(clk), .ARST_N_I(rst_n), .INSTR_VALID_I(vld),
    .INSTR_I(ins), .ARITH_WR_I(aw), .X_RDATA_I(xd), .Y_RDATA_I(yd), .MEM_REQ_O(rq),
    .FLAG_CLR_I(fclr), .LIMIT_O(lim), .SHIFT_O(sh), .PAIR_REJECT_O(rej),
    .PEEK_SEL_I(psel), .PEEK_DATA_O(pk));
  smu_mem_model mem_u (.clk_i(clk), .rst_n_i(rst_n), .req_i(rq), .x_o(xd), .y_o(yd));

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic go(input logic [15:0] s, input smu_acc_wr_s a);
    @(posedge clk);
    ins <= {s, 16'h0000};
    vld <= 1'b1;
    aw  <= a;
    @(posedge clk);
    vld <= 1'b0;
    aw  <= '0;
    #1;
  endtask

  // The extra edge lets a load's late register write land before sampling.
  task automatic peek(input logic [3:0] sel, input logic [31:0] exp);
    @(posedge clk);
    psel <= sel;
    repeat (2) @(posedge clk);
    #1;
    cmp(pk, exp);
  endtask

  task automatic t_index_load();
    @(posedge clk);
    ins <= 32'h1097_0000;
    vld <= 1'b1;
    @(posedge clk);
    ins <= 32'h10D7_0000;
    #1;
    cmp(stb, 32'h8);
    cmp(adr, 32'h0);
    @(posedge clk);
    vld <= 1'b0;
    #1;
    cmp(adr, 32'h1);
    peek(4'h2, 32'hC35A_0000);
    peek(4'h3, 32'hC35A_0001);
    cmp(flg, 32'h0);
  endtask

  task automatic t_regs();
    go(16'h1F38, '0);
    cmp(stb, 32'h2);
    cmp(adr, 32'h38);
    peek(4'hC, 32'h1E0F_0038);
    go(16'h40A7, '0);
    peek(4'hF, 32'hC35A_0000);
    go(16'h3127, '0);
    peek(4'h4, 32'hFFFF_FFFF);
    go(16'h315F, '0);
    peek(4'h5, 32'h0);
    go(16'h31B7, '0);
    peek(4'h6, 32'h2);
    cmp(flg, 32'h0);
  endtask

  task automatic t_stores();
    go(16'h27EF, '0);
    cmp(stb, 32'h4);
    cmp(rq.wdata, 32'hC35A_0000);
    cmp(flg, 32'h0);
    go(16'h2887, '0);
    cmp(stb, 32'h1);
    cmp(adr, 32'h2);
    cmp(rq.wdata, 32'hC35A_0000);
    go(16'h5000, '0);
    cmp({31'h0, rej}, 32'h1);
    cmp(stb, 32'h0);
  endtask

  // Modifier and index written from y2, then +modifier and -1 updates.
  task automatic t_index_modes();
    go(16'h41B8, '0);
    go(16'h41B0, '0);
    go(16'h1030, '0);
    cmp(adr, 32'h2);
    peek(4'h0, 32'hC35A_0002);
    go(16'h19E0, '0);
    cmp(adr, 32'h4);
    peek(4'h7, 32'h1E0F_0004);
    go(16'h3170, '0);
    peek(4'h5, 32'h3);
  endtask

  task automatic t_saturate();
    go(16'h1C45, '{1'b1, 3'h0, 72'h01_0000_1234_0000_0000});
    peek(4'h1, 32'h1E0F_0005);
    peek(4'h8, 32'h0000_1234);
    go(16'h2E10, '0);
    cmp(stb, 32'h1);
    cmp(rq.wdata, 32'h7FFF_FFFF);
    cmp(flg, 32'h5);
    repeat (6) @(posedge clk);
    #1;
    cmp(flg, 32'h5);
    @(posedge clk);
    fclr <= 1'b1;
    @(posedge clk);
    fclr <= 1'b0;
    #1;
    cmp(flg, 32'h0);
  endtask

  task automatic tally_and_finish();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_index_load();
    t_regs();
    t_stores();
    t_index_modes();
    t_saturate();
    tally_and_finish();
  end

  initial begin
    repeat (2000) @(posedge clk);
    errors++;
    tally_and_finish();
  end
endmodule // tb_top

`default_nettype wire
